/* File: dv/svr_store_sink.sv */
// Memory-side model that captures vector store bytes by address.
`timescale 1ns/1ps
module svr_store_sink (
   input wire logic         clk,
   input wire logic         st_valid,
   input wire logic [127:0] st_data,
   input wire logic [15:0]  st_byte_en
);
   // A filler value so that a missing byte lane is visible.
   logic [7:0] mem [16] = '{default: 8'h5a};
   // Byte lane i lands at address i; a disabled lane keeps old memory.
   always @(posedge clk) begin
      if (st_valid) begin
         for (int i = 0; i < 16; i++) begin
            if (st_byte_en[i]) mem[i] <= st_data[8*i +: 8];
         end
      end
   end
endmodule // svr_store_sink

/* File: dv/tb_svr_regfile.sv */
// Self-checking bench for the SIMD vector register state block.
`timescale 1ns/1ps
module tb_svr_regfile;
   logic clk, reset_n, vec_wr_en, vec_wr_zero_upper, vec_st_en, pint_wr_en, gpr_to_vec_en;
   logic cmp_flags_en, vec_st_valid, flags_wr, general_protection_fault;
   logic flush_to_zero, denormals_zero;
   logic [2:0] vec_wr_idx, vec_rd_a_idx, vec_rd_b_idx, vec_st_idx, pint_wr_idx, pint_rd_idx;
   logic [127:0] vec_wr_data, vec_rd_a_data, vec_rd_b_data, vec_st_data;
   logic [15:0] vec_st_byte_en;
   logic [63:0] pint_wr_data, pint_rd_data;
   logic [31:0] gpr_wr_data, vec_to_gpr_data, cmp_flags_in, flags_out, csr_wr_data;
   logic [31:0] simd_fp_control_status;
   logic [5:0] csr_flag_set, exc_masks;
   logic [1:0] round_ctrl;
   svr_pkg::svr_size_type vec_wr_size, vec_st_size;
   svr_pkg::svr_csr_cmd_type csr_cmd;
   int fail_count, num_checks, cycles;

   svr_regfile u_svr_regfile (.clk, .reset_n, .vec_wr_en, .vec_wr_idx, .vec_wr_size,
      .vec_wr_zero_upper, .vec_wr_data, .vec_rd_a_idx, .vec_rd_a_data, .vec_rd_b_idx,
      .vec_rd_b_data, .vec_st_en, .vec_st_idx, .vec_st_size, .vec_st_data, .vec_st_byte_en,
      .vec_st_valid, .pint_wr_en, .pint_wr_idx, .pint_wr_data, .pint_rd_idx, .pint_rd_data,
      .gpr_to_vec_en, .gpr_wr_data, .vec_to_gpr_data, .cmp_flags_en, .cmp_flags_in,
      .flags_out, .flags_wr, .csr_cmd, .csr_wr_data, .csr_flag_set, .simd_fp_control_status,
      .general_protection_fault, .exc_masks, .round_ctrl, .flush_to_zero, .denormals_zero);
   svr_store_sink u_svr_store_sink (.clk(clk), .st_valid(vec_st_valid),
      .st_data(vec_st_data), .st_byte_en(vec_st_byte_en));

   // Clock and a hang guard sized well above the few dozen cycles the tests need.
   always #20 clk = ~clk;
   always @(posedge clk) begin
      cycles++;
      if (cycles == 2000) begin
         fail_count++;
         test_done();
      end
   end

   task automatic chk(input string what, input logic [127:0] seen, input logic [127:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // Inputs always move at least 1 ns after the rising edge, so the design never races them.
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   function automatic logic [127:0] vpat(input int i);
      return {32{4'(i + 1)}};
   endfunction
   // The caller lowers vec_wr_en, so back-to-back writes never toggle it in one step.
   task automatic wv(input int i, input svr_pkg::svr_size_type s, input logic z,
                     input logic [127:0] d);
      vec_wr_en = 1'b1;
      vec_wr_idx = 3'(i);
      vec_wr_size = s;
      vec_wr_zero_upper = z;
      vec_wr_data = d;
      step(1);
   endtask
   function automatic logic [127:0] sunk();
      for (int i = 0; i < 16; i++) sunk[8*i +: 8] = u_svr_store_sink.mem[i];
   endfunction

   task automatic t_reset();
      vec_rd_a_idx = 3'h4;
      #1;
      chk("csr", 128'(simd_fp_control_status), 128'h1f80);
      chk("masks", 128'(exc_masks), 128'h3f);
      chk("ftz", 128'(flush_to_zero), 128'h0);
      chk("daz", 128'(denormals_zero), 128'h0);
      chk("vec", vec_rd_a_data, 128'h0);
      $display("done reset");
   endtask

   task automatic t_vec();
      for (int i = 0; i < 8; i++) wv(i, svr_pkg::SVR_SIZE_128, 1'b0, vpat(i));
      vec_wr_en = 1'b0;
      pint_wr_en = 1'b1;
      pint_wr_idx = 3'h2;
      pint_wr_data = 64'hffff_ffff_ffff_ffff;
      step(1);
      pint_wr_en = 1'b0;
      pint_rd_idx = 3'h2;
      for (int i = 0; i < 8; i++) begin
         vec_rd_a_idx = 3'(i);
         vec_rd_b_idx = 3'(7 - i);
         #1;
         chk("rd_a", vec_rd_a_data, vpat(i));
         chk("rd_b", vec_rd_b_data, vpat(7 - i));
      end
      chk("pint", 128'(pint_rd_data), 128'(64'hffff_ffff_ffff_ffff));
      vec_rd_a_idx = 3'h5;
      wv(5, svr_pkg::SVR_SIZE_32, 1'b0, {4{32'hdeadbeef}});
      wv(6, svr_pkg::SVR_SIZE_64, 1'b1, {16{8'ha5}});
      vec_wr_en = 1'b0;
      vec_rd_a_idx = 3'h5;
      vec_rd_b_idx = 3'h6;
      #1;
      chk("part32", vec_rd_a_data, (vpat(5) & ~128'hffff_ffff) | 128'hdeadbeef);
      chk("part64", vec_rd_b_data, {64'h0, {8{8'ha5}}});
      $display("done vectors");
   endtask

   task automatic t_store();
      vec_st_en = 1'b1;
      vec_st_idx = 3'h5;
      vec_st_size = svr_pkg::SVR_SIZE_32;
      step(1);
      chk("ben32", 128'(vec_st_byte_en), 128'h000f);
      chk("valid", 128'(vec_st_valid), 128'h1);
      vec_st_idx = 3'h6;
      vec_st_size = svr_pkg::SVR_SIZE_128;
      step(1);
      vec_st_en = 1'b0;
      chk("ben128", 128'(vec_st_byte_en), 128'hffff);
      chk("mem32", sunk(), {{12{8'h5a}}, 32'hdeadbeef});
      step(1);
      chk("mem128", sunk(), {64'h0, {8{8'ha5}}});
      chk("valid_end", 128'(vec_st_valid), 128'h0);
      $display("done stores");
   endtask

   task automatic t_csr();
      for (int c = 1; c < 3; c++) begin
         csr_cmd = svr_pkg::svr_csr_cmd_type'(c);
         csr_wr_data = 32'h8001_0000 >> (c - 1);
         step(1);
         csr_cmd = svr_pkg::SVR_CSR_NONE;
         chk("fault", 128'(general_protection_fault), 128'h1);
         chk("kept", 128'(simd_fp_control_status), 128'h1f80);
         step(1);
         chk("fault_end", 128'(general_protection_fault), 128'h0);
      end
      csr_cmd = svr_pkg::SVR_CSR_RESTORE;
      csr_wr_data = 32'h0000_e040;
      step(1);
      csr_cmd = svr_pkg::SVR_CSR_NONE;
      chk("restore", 128'(simd_fp_control_status), 128'he040);
      chk("fld", 128'({round_ctrl, flush_to_zero, denormals_zero, exc_masks}), 128'h3c0);
      csr_flag_set = 6'h21;
      step(1);
      csr_flag_set = 6'h00;
      step(3);
      chk("sticky", 128'(simd_fp_control_status), 128'he061);
      csr_cmd = svr_pkg::SVR_CSR_LOAD;
      csr_wr_data = 32'h0000_0000;
      step(1);
      csr_cmd = svr_pkg::SVR_CSR_NONE;
      chk("cleared", 128'(simd_fp_control_status), 128'h0);
      // A hardware flag set in the same cycle as a clearing load must survive.
      csr_cmd = svr_pkg::SVR_CSR_LOAD;
      csr_flag_set = 6'h04;
      step(1);
      csr_cmd = svr_pkg::SVR_CSR_NONE;
      csr_flag_set = 6'h00;
      chk("set_wins", 128'(simd_fp_control_status), 128'h4);
      $display("done control status");
   endtask

   task automatic t_misc();
      gpr_to_vec_en = 1'b1;
      vec_wr_idx = 3'h0;
      gpr_wr_data = 32'h1234_5678;
      step(1);
      gpr_to_vec_en = 1'b0;
      vec_rd_a_idx = 3'h0;
      cmp_flags_en = 1'b1;
      cmp_flags_in = 32'h0000_0045;
      #1;
      chk("gpr_in", vec_rd_a_data, (vpat(0) & ~128'hffff_ffff) | 128'h1234_5678);
      chk("gpr_out", 128'(vec_to_gpr_data), 128'h1234_5678);
      chk("flags", 128'({flags_wr, flags_out}), 128'h1_0000_0045);
      $display("done operands");
   endtask

   task automatic test_done();
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   // Main sequence: reset, each test, a second reset after the last test, then the verdict.
   initial begin
      {clk, reset_n, vec_wr_en, vec_wr_zero_upper, vec_st_en, pint_wr_en} = '0;
      {gpr_to_vec_en, cmp_flags_en, vec_wr_idx, vec_rd_a_idx, vec_rd_b_idx} = '0;
      {vec_st_idx, pint_wr_idx, pint_rd_idx, vec_wr_data, pint_wr_data} = '0;
      {gpr_wr_data, cmp_flags_in, csr_wr_data, csr_flag_set} = '0;
      vec_wr_size = svr_pkg::SVR_SIZE_32;
      vec_st_size = svr_pkg::SVR_SIZE_32;
      csr_cmd = svr_pkg::SVR_CSR_NONE;
      step(12);
      reset_n = 1'b1;
      t_reset();
      t_vec();
      t_store();
      t_csr();
      t_misc();
      cmp_flags_en = 1'b0;
      reset_n = 1'b0;
      step(2);
      reset_n = 1'b1;
      t_reset();
      test_done();
   end
endmodule // tb_svr_regfile

/* File: rtl/svr_pkg.sv */
// Package of constants for the SIMD vector register state block.
package svr_pkg;
   localparam int unsigned VEC_WIDTH       = 128;
   localparam int unsigned VEC_COUNT       = 8;
   localparam int unsigned VEC_IDX_WIDTH   = 3;
   localparam int unsigned PINT_WIDTH      = 64;
   localparam int unsigned CSR_WIDTH       = 32;
   localparam int unsigned BYTES_PER_VEC   = 16;
   localparam int unsigned LANE_WIDTH      = 32;
   // Control/status field positions.
   localparam int unsigned FLAG_LSB        = 0;
   localparam int unsigned FLAG_MSB        = 5;
   localparam int unsigned DAZ_BIT         = 6;
   localparam int unsigned MASK_LSB        = 7;
   localparam int unsigned MASK_MSB        = 12;
   localparam int unsigned RC_LSB          = 13;
   localparam int unsigned RC_MSB          = 14;
   localparam int unsigned FTZ_BIT         = 15;
   localparam int unsigned RSVD_LSB        = 16;
   localparam int unsigned RSVD_MSB        = 31;
   // Reset value: all masks set, flags, modes and reserved bits clear.
   localparam logic [31:0] CSR_RESET       = 32'h0000_1f80;
   localparam logic [31:0] CSR_RSVD_MASK   = 32'hffff_0000;
   // Transfer size encodings for vector loads and stores.
   typedef enum logic [1:0] {
      SVR_SIZE_32,
      SVR_SIZE_64,
      SVR_SIZE_128
   } svr_size_type;
   // Control/status access commands.
   typedef enum logic [1:0] {
      SVR_CSR_NONE,
      SVR_CSR_LOAD,
      SVR_CSR_RESTORE
   } svr_csr_cmd_type;
endpackage

/* File: rtl/svr_regfile.sv */
// Vector register file, packed-integer registers and SIMD control/status register.
`timescale 1ns/1ps
module svr_regfile #(
   parameter int unsigned NUM_VEC = 8
) (
   input  wire logic                      clk,
   input  wire logic                      reset_n,
   // Vector write port (load or execution result).
   input  wire logic                      vec_wr_en,
   input  wire logic [2:0]                vec_wr_idx,
   input  wire svr_pkg::svr_size_type     vec_wr_size,
   input  wire logic                      vec_wr_zero_upper,
   input  wire logic [127:0]              vec_wr_data,
   // Two vector read ports.
   input  wire logic [2:0]                vec_rd_a_idx,
   output logic      [127:0]              vec_rd_a_data,
   input  wire logic [2:0]                vec_rd_b_idx,
   output logic      [127:0]              vec_rd_b_data,
   // Store port: sized store data with byte enables, lowest byte in lane 0.
   input  wire logic                      vec_st_en,
   input  wire logic [2:0]                vec_st_idx,
   input  wire svr_pkg::svr_size_type     vec_st_size,
   output logic      [127:0]              vec_st_data,
   output logic      [15:0]               vec_st_byte_en,
   output logic                           vec_st_valid,
   // Packed-integer register file port.
   input  wire logic                      pint_wr_en,
   input  wire logic [2:0]                pint_wr_idx,
   input  wire logic [63:0]               pint_wr_data,
   input  wire logic [2:0]                pint_rd_idx,
   output logic      [63:0]               pint_rd_data,
   // General register operand into and out of a vector low doubleword.
   input  wire logic                      gpr_to_vec_en,
   input  wire logic [31:0]               gpr_wr_data,
   output logic      [31:0]               vec_to_gpr_data,
   // Compare outcome to processor flags register.
   input  wire logic                      cmp_flags_en,
   input  wire logic [31:0]               cmp_flags_in,
   output logic      [31:0]               flags_out,
   output logic                           flags_wr,
   // Control/status access.
   input  wire svr_pkg::svr_csr_cmd_type  csr_cmd,
   input  wire logic [31:0]               csr_wr_data,
   input  wire logic [5:0]                csr_flag_set,
   output logic      [31:0]               simd_fp_control_status,
   output logic                           general_protection_fault,
   // Decoded control/status fields for the datapaths.
   output logic      [5:0]                exc_masks,
   output logic      [1:0]                round_ctrl,
   output logic                           flush_to_zero,
   output logic                           denormals_zero
);
   logic [127:0] vec_val   [NUM_VEC];
   logic [63:0]  pint_q    [8];
   logic [NUM_VEC-1:0] sel_wr;
   logic [127:0] wr_data_mux;
   svr_pkg::svr_size_type wr_size_mux;
   logic         wr_zero_mux;
   logic [31:0]  csr_q;
   logic [31:0]  csr_d;
   logic         csr_wr_req;
   logic         csr_rsvd_bad;
   logic         csr_accept;
   logic [127:0] st_src;
   logic [15:0]  st_be;
   logic         gpf_q;
   logic         st_valid_q;
   logic [127:0] st_data_q;
   logic [15:0]  st_be_q;

   // A general register move is a 32-bit write to the low doubleword.
   assign wr_data_mux = gpr_to_vec_en ? {96'h0, gpr_wr_data} : vec_wr_data;
   assign wr_size_mux = gpr_to_vec_en ? svr_pkg::SVR_SIZE_32 : vec_wr_size;
   assign wr_zero_mux = gpr_to_vec_en ? 1'b0 : vec_wr_zero_upper;

   // One lane module per vector register; storage is private to this block.
   genvar gi;
   generate
      for (gi = 0; gi < NUM_VEC; gi++) begin : g_vec
         assign sel_wr[gi] = (vec_wr_en || gpr_to_vec_en)
                             && (vec_wr_idx == 3'(gi));
         svr_vec_lane #(
            .WIDTH (svr_pkg::VEC_WIDTH)
         ) u_lane (
            .clk           (clk),
            .reset_n       (reset_n),
            .wr_en         (sel_wr[gi]),
            .wr_size       (wr_size_mux),
            .wr_zero_upper (wr_zero_mux),
            .wr_data       (wr_data_mux),
            .value         (vec_val[gi])
         );
      end
   endgenerate

   // Read ports; lanes of four singles pass through untouched.
   assign vec_rd_a_data   = vec_val[vec_rd_a_idx];
   assign vec_rd_b_data   = vec_val[vec_rd_b_idx];
   assign vec_to_gpr_data = vec_val[vec_rd_a_idx][31:0];
   // No vector output goes to any address path; addresses come from outside.

   // Store data keeps byte 0 of the register in byte lane 0 (lowest address).
   assign st_src = vec_val[vec_st_idx];
   assign st_be  = (vec_st_size == svr_pkg::SVR_SIZE_32) ? 16'h000f :
                   (vec_st_size == svr_pkg::SVR_SIZE_64) ? 16'h00ff : 16'hffff;

   // Registered store answer, one cycle after the request.
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         st_valid_q <= 1'b0;
         st_data_q  <= '0;
         st_be_q    <= '0;
      end else begin
         st_valid_q <= vec_st_en;
         st_data_q  <= vec_st_en ? st_src : st_data_q;
         st_be_q    <= vec_st_en ? st_be : st_be_q;
      end
   end
   assign vec_st_valid   = st_valid_q;
   assign vec_st_data    = st_data_q;
   assign vec_st_byte_en = st_be_q;

   // Packed-integer registers, independent from the vector storage.
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         for (int i = 0; i < 8; i++) pint_q[i] <= '0;
      end else if (pint_wr_en) begin
         pint_q[pint_wr_idx] <= pint_wr_data;
      end
   end
   assign pint_rd_data = pint_q[pint_rd_idx];

   // Compare results are forwarded to the flags register, not a vector.
   assign flags_wr  = cmp_flags_en;
   assign flags_out = cmp_flags_in;

   // Reserved-bit check: a load or restore with upper bits set is refused.
   assign csr_wr_req   = (csr_cmd == svr_pkg::SVR_CSR_LOAD)
                         || (csr_cmd == svr_pkg::SVR_CSR_RESTORE);
   assign csr_rsvd_bad = |(csr_wr_data & svr_pkg::CSR_RSVD_MASK);
   assign csr_accept   = csr_wr_req && !csr_rsvd_bad;
   // Hardware flag sets win over a same-cycle software clear of that flag.
   assign csr_d = csr_accept
                  ? (csr_wr_data | {26'h0, csr_flag_set})
                  : (csr_q | {26'h0, csr_flag_set});

   // No mode gating exists: every execution mode may reach these registers.
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         csr_q <= svr_pkg::CSR_RESET;
         gpf_q <= 1'b0;
      end else begin
         csr_q <= csr_d;
         gpf_q <= csr_wr_req && csr_rsvd_bad;
      end
   end

   // Field view; store and save read the whole register.
   assign simd_fp_control_status   = csr_q;
   assign general_protection_fault = gpf_q;
   assign exc_masks      = csr_q[svr_pkg::MASK_MSB:svr_pkg::MASK_LSB];
   assign round_ctrl     = csr_q[svr_pkg::RC_MSB:svr_pkg::RC_LSB];
   assign flush_to_zero  = csr_q[svr_pkg::FTZ_BIT];
   assign denormals_zero = csr_q[svr_pkg::DAZ_BIT];

   // Reserved bits stay clear whatever happens.
   rsvd_zero_a: assert property (@(posedge clk) disable iff (!reset_n)
      (csr_q[31:16] == 16'h0000)) else $error("reserved bits set");
   // A bad write leaves the register as it was and faults next cycle.
   bad_write_a: assert property (@(posedge clk) disable iff (!reset_n)
      (csr_wr_req && csr_rsvd_bad && csr_flag_set == 6'h00)
      |=> (general_protection_fault && $stable(csr_q)))
      else $error("reserved write not refused");
   // A good load lands exactly.
   good_load_a: assert property (@(posedge clk) disable iff (!reset_n)
      (csr_accept && csr_flag_set == 6'h00) |=> (csr_q == $past(csr_wr_data)))
      else $error("load value lost");
   // Flags never drop without an accepted write.
   sticky_flags_a: assert property (@(posedge clk) disable iff (!reset_n)
      (!csr_accept) |=> ((csr_q[5:0] & $past(csr_q[5:0])) == $past(csr_q[5:0])))
      else $error("flag dropped");
   // Masks set, modes clear right after reset.
   reset_value_a: assert property (@(posedge clk)
      (!reset_n) |=> (csr_q[12:7] == 6'h3f && !csr_q[15] && !csr_q[6]))
      else $error("bad reset value");
   // A 32-bit store enables the low four byte lanes.
   store_size_a: assert property (@(posedge clk) disable iff (!reset_n)
      (vec_st_en && vec_st_size == svr_pkg::SVR_SIZE_32) |=> (vec_st_byte_en == 16'h000f))
      else $error("store enables wrong");
   // Store returns the register in ascending byte order.
   store_data_a: assert property (@(posedge clk) disable iff (!reset_n)
      (vec_st_en && !(vec_wr_en || gpr_to_vec_en)) |=> (vec_st_data == $past(st_src)))
      else $error("store data wrong");
   // A 32-bit write keeps the upper bits of the target.
   partial_keep_a: assert property (@(posedge clk) disable iff (!reset_n)
      (vec_wr_en && !gpr_to_vec_en && vec_wr_size == svr_pkg::SVR_SIZE_32
       && !vec_wr_zero_upper && vec_rd_a_idx == vec_wr_idx)
      |=> (vec_val[$past(vec_wr_idx)][127:32] == $past(vec_rd_a_data[127:32])))
      else $error("upper bits lost");
   // A packed-integer write never changes a vector register.
   pint_isolated_a: assert property (@(posedge clk) disable iff (!reset_n)
      (pint_wr_en && !vec_wr_en && !gpr_to_vec_en)
      |=> (vec_val[$past(vec_rd_a_idx)] == $past(vec_rd_a_data)))
      else $error("vector changed by packed-integer write");
endmodule // svr_regfile

/* File: rtl/svr_vec_lane.sv */
// One 128-bit vector register with sized partial write support.
`timescale 1ns/1ps
module svr_vec_lane #(
   parameter int unsigned WIDTH = 128
) (
   input  wire logic                clk,
   input  wire logic                reset_n,
   input  wire logic                wr_en,
   input  wire svr_pkg::svr_size_type wr_size,
   input  wire logic                wr_zero_upper,
   input  wire logic [WIDTH-1:0]    wr_data,
   output logic      [WIDTH-1:0]    value
);
   logic [WIDTH-1:0] value_q;
   logic [WIDTH-1:0] value_d;
   logic [WIDTH-1:0] keep_mask;

   // Bits outside the written piece are kept unless the op asks to zero them.
   assign keep_mask = (wr_size == svr_pkg::SVR_SIZE_32) ? {{(WIDTH-32){1'b1}}, 32'h0000_0000} :
                      (wr_size == svr_pkg::SVR_SIZE_64) ? {{(WIDTH-64){1'b1}}, 64'h0} :
                      {WIDTH{1'b0}};
   assign value_d = wr_zero_upper ? (wr_data & ~keep_mask)
                                  : ((value_q & keep_mask) | (wr_data & ~keep_mask));

   // Contents are architectural data, so reset clears them to a known value.
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         value_q <= '0;
      end else if (wr_en) begin
         value_q <= value_d;
      end
   end
   assign value = value_q;
endmodule // svr_vec_lane
